/* File: hdl/emcal_pkg.sv */
package emcal_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CLR   = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h10;
  localparam logic [7:0] ADDR_TGT_I     = 8'h14;
  localparam logic [7:0] ADDR_TGT_V     = 8'h18;
  localparam logic [7:0] ADDR_TGT_P     = 8'h1c;
  localparam logic [7:0] ADDR_GAIN_I    = 8'h20;
  localparam logic [7:0] ADDR_GAIN_V    = 8'h24;
  localparam logic [7:0] ADDR_GAIN_P    = 8'h28;
  localparam logic [7:0] ADDR_RANGE     = 8'h2c;
  localparam logic [7:0] ADDR_PHASE     = 8'h30;
  localparam logic [7:0] ADDR_OFS_I     = 8'h34;
  localparam logic [7:0] ADDR_OFS_P     = 8'h38;
  localparam logic [7:0] ADDR_OFS_Q     = 8'h3c;
  localparam logic [7:0] ADDR_DC_TRIM   = 8'h40;
  localparam logic [7:0] ADDR_OUT_I     = 8'h44;
  // Control bit positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_DC_BIT    = 1;
  // Status / interrupt bit positions
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_ACK_BIT     = 1;
  localparam int ST_NAK_BIT     = 2;
  localparam int IRQ_W          = 2;
  // Gain acceptance window
  localparam logic [16:0] GAIN_MIN = 17'd25000;
  localparam logic [16:0] GAIN_MAX = 17'd65535;
  // Reset values
  localparam logic [15:0] GAIN_RST  = 16'h8000;
  localparam logic [4:0]  RANGE_RST = 5'h0c;
  // Divider length: quotient width in cycles
  localparam int DIV_STEPS = 48;
  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : emcal_pkg

/* File: hdl/emcal_if.sv */
`timescale 1ns/10ps
`default_nettype none
// Request/answer between sequencer and gain divider
interface emcal_if;
  logic        start;     // One-cycle start pulse
  logic [15:0] gain_old;  // Present gain
  logic [31:0] expect_v;  // Expected value
  logic [31:0] meas_v;    // Measured value
  logic        done;      // One-cycle result pulse
  logic [47:0] quot;      // gain_old*expect/meas
  modport master (output start, gain_old, expect_v, meas_v,
                  input done, quot);
  modport slave  (input start, gain_old, expect_v, meas_v,
                  output done, quot);
endinterface : emcal_if
`default_nettype wire

/* File: hdl/emcal_div.sv */
`timescale 1ns/10ps
`default_nettype none
// Restoring divider: quot = gain_old*expect/meas, one bit per cycle
module emcal_div
  import emcal_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  emcal_if.slave    dv
);
  logic [47:0] num, next_num;      // Dividend shifting out
  logic [48:0] rem, next_rem;      // Partial remainder
  logic [47:0] q, next_q;          // Quotient bits
  logic [5:0]  cnt, next_cnt;      // Steps left
  logic        busy, next_busy;    // Division running
  logic        done, next_done;    // Result pulse
  logic [31:0] dvs, next_dvs;      // Latched divisor
  logic [48:0] trial;              // Shifted remainder

  // Next-state of one division step
  always_comb
  begin
    next_num  = num;
    next_rem  = rem;
    next_q    = q;
    next_cnt  = cnt;
    next_busy = busy;
    next_dvs  = dvs;
    next_done = 1'b0;
    trial     = {rem[47:0], num[47]};
    if (dv.start)
    begin
      // Product fits 48 bits: 16 x 32
      next_num  = 48'(dv.gain_old) * 48'(dv.expect_v); // R3
      next_rem  = '0;
      next_q    = '0;
      next_dvs  = dv.meas_v;
      next_cnt  = 6'(DIV_STEPS);
      next_busy = 1'b1;
    end
    else if (busy)
    begin
      next_num = {num[46:0], 1'b0};
      // Zero divisor saturates quotient to all ones, so it fails range
      if (trial >= {17'h0, dvs})
      begin
        next_rem = trial - {17'h0, dvs};
        next_q   = {q[46:0], 1'b1};
      end
      else
      begin
        next_rem = trial;
        next_q   = {q[46:0], 1'b0};
      end
      next_cnt = cnt - 6'h01;
      if (cnt == 6'h01)
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  // Divider registers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      num  <= '0;
      rem  <= '0;
      q    <= '0;
      cnt  <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      dvs  <= '0;
    end
    else
    begin
      num  <= next_num;
      rem  <= next_rem;
      q    <= next_q;
      cnt  <= next_cnt;
      busy <= next_busy;
      done <= next_done;
      dvs  <= next_dvs;
    end
  end

  assign dv.done = done;
  assign dv.quot = q;
endmodule : emcal_div
`default_nettype wire

/* File: hdl/emcal_top.sv */
// How it works
// R1 - Expected values come from target registers
// R2 - Gain command rewrites current, voltage, power gains
// R3 - New gain equals old times expected/measured
// R4 - ACK only if all gains in 25000..65535
// R5 - On NAK old gains stay unchanged
// R6 - Gain product right-shifted by range count
// R7 - Each range step halves the output
// R8 - Phase setting is signed low byte
// R9 - Host converts degrees at 40 units each
// R10 - Three AC offset registers exist
// R11 - DC mode bypasses both high-pass filters
// R12 - DC current trim added at ADC output
// R13 - Host may save constants after success
// R14 - Host calibrates offsets at no load
`timescale 1ns/10ps
`default_nettype none
module emcal_top
  import emcal_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [23:0] adc_i,        // Current ADC sample
  input  wire logic [23:0] adc_v,        // Voltage ADC sample
  input  wire logic [31:0] meas_i,       // Measured current RMS
  input  wire logic [31:0] meas_v,       // Measured voltage RMS
  input  wire logic [31:0] meas_p,       // Measured active power
  input  wire logic [31:0] rms_raw_i,    // Pre-gain current RMS
  output logic [23:0]      adc_i_trim,   // Current after DC trim
  output logic [23:0]      adc_v_out,    // Voltage sample passed on
  output logic             hpf_bypass,   // High-pass filters off
  output logic signed [7:0] phase_comp,  // Signed phase step
  output logic             irq
);
  typedef enum logic [3:0] {
    EMCAL_IDLE = 4'b0001,
    EMCAL_RUN  = 4'b0010,
    EMCAL_WAIT = 4'b0100,
    EMCAL_DONE = 4'b1000
  } emcal_state_t;

  // Software-visible state
  logic [31:0] tgt [3];             // Targets I, V, P
  logic [15:0] gain [3];            // Gains I, V, P
  logic [31:0] ofs [3];             // AC offsets I, P, Q
  logic [4:0]  range_sh;            // Right-shift count
  logic [15:0] phase_reg;           // Phase register, low byte used
  logic [23:0] dc_current_trim;     // DC current offset
  logic        dc_mode;             // DC application mode
  logic [IRQ_W-1:0] irq_stat, irq_en;
  logic        last_ack, last_nak;  // Outcome of last command

  // Bus handshake state
  logic aw_hold, w_hold;            // Captured address / data
  logic [7:0]  aw_a;
  logic [31:0] w_d;
  logic [3:0]  w_s;
  logic        wr_go, rd_go;        // Accepted accesses

  // Sequencer state
  emcal_state_t st, next_st;
  logic [1:0]  idx, next_idx;       // Quantity under work
  logic [15:0] res [3];             // Candidate gains
  logic        all_ok, next_all_ok; // Every gain in window
  logic        cmd_start;           // Software start pulse
  emcal_if     dv ();

  emcal_div u_div (
    .clock (clock),
    .rst_n (rst_n),
    .dv    (dv)
  );

  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = (aw_hold || s_axi_awvalid) && (w_hold || s_axi_wvalid)
                 && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign cmd_start = wr_go && (aw_hold ? aw_a : s_axi_awaddr) == ADDR_CTRL
                     && (w_hold ? w_s[0] : s_axi_wstrb[0])
                     && (w_hold ? w_d[CTRL_START_BIT]
                                : s_axi_wdata[CTRL_START_BIT]);

  // Byte-lane merge helper
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
      if (s[b])
        r[8*b +: 8] = n[8*b +: 8];
    return r;
  endfunction : merge

  // Register write path, address/data taken in either order
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_a    <= '0;
      w_d     <= '0;
      w_s     <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      tgt  <= '{default: '0};
      ofs  <= '{default: '0};
      gain <= '{default: GAIN_RST};
      range_sh  <= RANGE_RST;
      phase_reg <= '0;
      dc_current_trim <= '0;
      dc_mode   <= 1'b0;
      irq_en    <= '0;
      irq_stat  <= '0;
    end
    else
    begin : wr
      logic [7:0]  a;
      logic [31:0] d;
      logic [3:0]  s;
      logic [IRQ_W-1:0] clr;
      a   = aw_hold ? aw_a : s_axi_awaddr;
      d   = w_hold ? w_d : s_axi_wdata;
      s   = w_hold ? w_s : s_axi_wstrb;
      clr = '0;
      if (s_axi_awvalid && s_axi_awready && !wr_go)
      begin
        aw_hold <= 1'b1;
        aw_a    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !wr_go)
      begin
        w_hold <= 1'b1;
        w_d    <= s_axi_wdata;
        w_s    <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go)
      begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= RESP_OKAY;
        unique case (a)
          ADDR_CTRL:    dc_mode <= s[0] ? d[CTRL_DC_BIT] : dc_mode;
          ADDR_IRQ_CLR: clr = d[IRQ_W-1:0] & {IRQ_W{s[0]}};
          ADDR_IRQ_EN:  irq_en <= s[0] ? d[IRQ_W-1:0] : irq_en;
          ADDR_TGT_I:   tgt[0] <= merge(tgt[0], d, s); // R1
          ADDR_TGT_V:   tgt[1] <= merge(tgt[1], d, s); // R1
          ADDR_TGT_P:   tgt[2] <= merge(tgt[2], d, s); // R1
          ADDR_GAIN_I:  gain[0] <= 16'(merge({16'h0, gain[0]}, d, s));
          ADDR_GAIN_V:  gain[1] <= 16'(merge({16'h0, gain[1]}, d, s));
          ADDR_GAIN_P:  gain[2] <= 16'(merge({16'h0, gain[2]}, d, s));
          ADDR_RANGE:   range_sh <= s[0] ? d[4:0] : range_sh;
          ADDR_PHASE:   phase_reg <= 16'(merge({16'h0, phase_reg}, d, s));
          ADDR_OFS_I:   ofs[0] <= merge(ofs[0], d, s); // R10
          ADDR_OFS_P:   ofs[1] <= merge(ofs[1], d, s); // R10
          ADDR_OFS_Q:   ofs[2] <= merge(ofs[2], d, s); // R10
          ADDR_DC_TRIM: dc_current_trim <= 24'(merge({8'h0,
                                   dc_current_trim}, d, s));
          ADDR_STATUS, ADDR_IRQ_STAT, ADDR_OUT_I: ;
          default:      s_axi_bresp <= RESP_SLVERR;
        endcase
      end
      // Commit only on success, a failed run keeps old gains
      if (st == EMCAL_DONE && all_ok)
        for (int k = 0; k < 3; k++)
          gain[k] <= res[k]; // R2 R5
      // Set beats clear in the same cycle
      irq_stat <= (irq_stat & ~clr)
                  | ({IRQ_W{st == EMCAL_DONE}} & {!all_ok, all_ok});
    end
  end

  // Sequencer next state: three divisions, each quotient range checked
  always_comb
  begin
    next_st     = st;
    next_idx    = idx;
    next_all_ok = all_ok;
    dv.start    = 1'b0;
    dv.gain_old = gain[idx];
    dv.expect_v = tgt[idx]; // R1
    dv.meas_v   = idx == 2'd0 ? meas_i : idx == 2'd1 ? meas_v : meas_p;
    unique case (st)
      EMCAL_IDLE:
        if (cmd_start)
        begin
          next_st     = EMCAL_RUN;
          next_idx    = '0;
          next_all_ok = 1'b1;
        end
      EMCAL_RUN:
      begin
        dv.start = 1'b1;
        next_st  = EMCAL_WAIT;
      end
      EMCAL_WAIT:
        if (dv.done)
        begin
          // Inclusive window on the full-width quotient
          if (dv.quot < 48'(GAIN_MIN) || dv.quot > 48'(GAIN_MAX))
            next_all_ok = 1'b0; // R4
          next_idx = idx + 2'd1;
          next_st  = idx == 2'd2 ? EMCAL_DONE : EMCAL_RUN;
        end
      EMCAL_DONE:
        next_st = EMCAL_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st       <= EMCAL_IDLE;
      idx      <= '0;
      all_ok   <= 1'b0;
      res      <= '{default: '0};
      last_ack <= 1'b0;
      last_nak <= 1'b0;
    end
    else
    begin
      st     <= next_st;
      idx    <= next_idx;
      all_ok <= next_all_ok;
      if (st == EMCAL_WAIT && dv.done)
        res[idx] <= dv.quot[15:0]; // R3
      if (st == EMCAL_DONE)
      begin
        last_ack <= all_ok; // R4
        last_nak <= !all_ok;
      end
    end
  end

  // Read path, data registered
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_CTRL:     s_axi_rdata <= {30'h0, dc_mode, 1'b0};
        ADDR_STATUS:   s_axi_rdata <= {29'h0, last_nak, last_ack,
                                       st != EMCAL_IDLE};
        ADDR_IRQ_STAT: s_axi_rdata <= {30'h0, irq_stat};
        ADDR_IRQ_CLR:  s_axi_rdata <= '0;
        ADDR_IRQ_EN:   s_axi_rdata <= {30'h0, irq_en};
        ADDR_TGT_I:    s_axi_rdata <= tgt[0];
        ADDR_TGT_V:    s_axi_rdata <= tgt[1];
        ADDR_TGT_P:    s_axi_rdata <= tgt[2];
        ADDR_GAIN_I:   s_axi_rdata <= {16'h0, gain[0]};
        ADDR_GAIN_V:   s_axi_rdata <= {16'h0, gain[1]};
        ADDR_GAIN_P:   s_axi_rdata <= {16'h0, gain[2]};
        ADDR_RANGE:    s_axi_rdata <= {27'h0, range_sh};
        ADDR_PHASE:    s_axi_rdata <= {16'h0, phase_reg};
        ADDR_OFS_I:    s_axi_rdata <= ofs[0];
        ADDR_OFS_P:    s_axi_rdata <= ofs[1];
        ADDR_OFS_Q:    s_axi_rdata <= ofs[2];
        ADDR_DC_TRIM:  s_axi_rdata <= {8'h0, dc_current_trim};
        // Scaled current: product shifted right by range
        ADDR_OUT_I:    s_axi_rdata <= 32'(({16'h0, rms_raw_i} * gain[0])
                                         >> range_sh); // R6 R7
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Sample path: trim ahead of every other stage
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      adc_i_trim <= '0;
      adc_v_out  <= '0;
      hpf_bypass <= 1'b0;
      phase_comp <= '0;
      irq        <= 1'b0;
    end
    else
    begin
      adc_i_trim <= adc_i + dc_current_trim; // R12
      adc_v_out  <= adc_v;
      hpf_bypass <= dc_mode; // R11
      phase_comp <= signed'(phase_reg[7:0]); // R8
      irq        <= |(irq_stat & irq_en);
    end
  end

  chk_nak_keeps_gain: assert property (@(posedge clock) disable iff (!rst_n)
    st == EMCAL_DONE && !all_ok |=> gain[0] == $past(gain[0])
      || $past(wr_go)) else $error("gain changed on failure"); // R5
  chk_ack_window: assert property (@(posedge clock) disable iff (!rst_n)
    st == EMCAL_DONE && all_ok |=> gain[0] >= 16'(GAIN_MIN)
      || $past(wr_go)) else $error("accepted gain below limit"); // R4
  chk_trim_adds: assert property (@(posedge clock) disable iff (!rst_n)
    1'b1 |=> adc_i_trim == $past(adc_i) + $past(dc_current_trim))
    else $error("dc trim not applied"); // R12
  chk_hpf_follow: assert property (@(posedge clock) disable iff (!rst_n)
    1'b1 |=> hpf_bypass == $past(dc_mode))
    else $error("bypass mismatch"); // R11
  chk_phase_sign: assert property (@(posedge clock) disable iff (!rst_n)
    1'b1 |=> phase_comp[7] == $past(phase_reg[7]))
    else $error("phase sign lost"); // R8
  chk_cmd_ends: assert property (@(posedge clock) disable iff (!rst_n)
    st == EMCAL_RUN && idx == 2'd0 |-> ##[1:160] st == EMCAL_DONE)
    else $error("gain command hangs"); // R2
  chk_ack_nak_one: assert property (@(posedge clock) disable iff (!rst_n)
    !(last_ack && last_nak)) else $error("ack and nak together"); // R4
  chk_res_ratio: assert property (@(posedge clock) disable iff (!rst_n)
    st == EMCAL_WAIT && dv.done && dv.meas_v != 0 |->
      dv.quot * dv.meas_v <= 80'(dv.gain_old) * dv.expect_v)
    else $error("quotient too large"); // R3
  cov_ack: cover property (@(posedge clock) st == EMCAL_DONE && all_ok);
  cov_nak: cover property (@(posedge clock) st == EMCAL_DONE && !all_ok);
  cov_irq: cover property (@(posedge clock) irq);
endmodule : emcal_top
`default_nettype wire

/* File: dv/emcal_host.sv */
`timescale 1ns/10ps
`default_nettype none
// Host side: AXI4-Lite master issuing calibration traffic
module emcal_host
(
  input  wire logic        clock,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // Idle bus from time zero
  initial
  begin
    awaddr  = 8'h00;
    awvalid = 1'b0;
    wdata   = 32'h0;
    wstrb   = 4'hf;
    wvalid  = 1'b0;
    bready  = 1'b0;
    araddr  = 8'h00;
    arvalid = 1'b0;
    rready  = 1'b0;
  end

  // One write; address and data released on their own handshakes
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge clock);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clock);
      // Released lines show the inverse, not a stale copy
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
    end
    do @(posedge clock); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : write_reg

  // One read; rready held until the data arrives
  task automatic read_reg(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    araddr  <= ~a;
    do @(posedge clock); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : read_reg

  // Degrees to phase units, added to the old setting
  function automatic logic [15:0] phase_word(input logic [15:0] old,
                                             input int deg);
    phase_word = old + 16'(deg * 40);
  endfunction : phase_word
endmodule : emcal_host
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import emcal_pkg::*;
  logic        clock, rst_n;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, hpf_bypass, irq;
  logic [23:0] adc_i, adc_v, adc_i_trim, adc_v_out;
  logic [31:0] meas_i, meas_v, meas_p, rms_raw_i;
  logic signed [7:0] phase_comp;
  int          err_total, samples_checked, cycles;

  emcal_top dut_u (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .adc_i(adc_i), .adc_v(adc_v), .meas_i(meas_i), .meas_v(meas_v),
    .meas_p(meas_p), .rms_raw_i(rms_raw_i), .adc_i_trim(adc_i_trim),
    .adc_v_out(adc_v_out), .hpf_bypass(hpf_bypass),
    .phase_comp(phase_comp), .irq(irq));

  emcal_host host_u (.clock(clock), .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid), .awready(s_axi_awready), .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb), .wvalid(s_axi_wvalid), .wready(s_axi_wready),
    .bresp(s_axi_bresp), .bvalid(s_axi_bvalid), .bready(s_axi_bready),
    .araddr(s_axi_araddr), .arvalid(s_axi_arvalid),
    .arready(s_axi_arready), .rdata(s_axi_rdata), .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid), .rready(s_axi_rready));

  // 20 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Hang guard: whole run needs under a thousand cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    host_u.write_reg(a, d, r);
  endtask : wr

  // Read and compare data and response code
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = RESP_OKAY);
    logic [31:0] d;
    logic [1:0]  r;
    host_u.read_reg(a, d, r);
    check(d, e);
    check({30'h0, r}, {30'h0, er});
  endtask : rd

  // Start a gain command and poll until the engine is idle again
  task automatic run_cal(input logic [31:0] st);
    logic [31:0] s;
    logic [1:0]  r;
    s = 32'h1;
    wr(ADDR_CTRL, 32'h1);
    for (int n = 0; n < 400 && s[0] !== 1'b0; n++)
      host_u.read_reg(ADDR_STATUS, s, r);
    check(s, st);
  endtask : run_cal

  task automatic set_meas(input logic [31:0] i, v, p);
    @(posedge clock);
    meas_i <= i;
    meas_v <= v;
    meas_p <= p;
  endtask : set_meas

  task automatic t_reset();
    rd(ADDR_GAIN_I, 32'(GAIN_RST));
    rd(ADDR_GAIN_P, 32'(GAIN_RST));
    rd(ADDR_RANGE, 32'(RANGE_RST));
    rd(8'h48, 32'h0, RESP_SLVERR); // Unmapped place
  endtask : t_reset

  // Readback shifts the gained product right by the range count
  task automatic t_range();
    int rs[5] = '{0, 12, 13, 14, 31};
    @(posedge clock);
    rms_raw_i <= 32'd2300;
    wr(ADDR_GAIN_I, 32'h4000);
    foreach (rs[k])
    begin
      wr(ADDR_RANGE, 32'(rs[k]));
      rd(ADDR_OUT_I, 32'((64'd2300 * 64'h4000) >> rs[k]));
    end
  endtask : t_range

  // Upper byte of the phase word must not reach the signed step
  task automatic t_phase();
    logic [15:0] w;
    w = host_u.phase_word(16'h0005, -1);
    wr(ADDR_PHASE, {16'h0, w});
    rd(ADDR_PHASE, 32'h0000ffdd);
    check({24'h0, phase_comp}, 32'h000000dd);
  endtask : t_phase

  task automatic t_offsets();
    logic [7:0] a[3] = '{ADDR_OFS_I, ADDR_OFS_P, ADDR_OFS_Q};
    set_meas(32'h0, 32'h0, 32'h0);
    foreach (a[k]) wr(a[k], 32'h120 + k);
    foreach (a[k]) rd(a[k], 32'h120 + k);
  endtask : t_offsets

  // Measured inputs set before the command; only voltage matches its target
  task automatic t_cal_ack();
    set_meas(32'd1150, 32'd2000, 32'd2);
    wr(ADDR_TGT_I, 32'd1000);
    wr(ADDR_TGT_V, 32'd2000);
    wr(ADDR_TGT_P, 32'd3);
    wr(ADDR_GAIN_I, 32'(GAIN_RST)); // Range test left a smaller gain
    wr(ADDR_IRQ_EN, 32'h3);
    run_cal(32'h2);
    rd(ADDR_GAIN_I, (32'(GAIN_RST) * 1000) / 1150);
    rd(ADDR_GAIN_V, 32'(GAIN_RST));
    rd(ADDR_GAIN_P, (32'(GAIN_RST) * 3) / 2);
    check({31'h0, irq}, 32'h1);
    wr(ADDR_IRQ_CLR, 32'h1);
    rd(ADDR_IRQ_STAT, 32'h0);
    check({31'h0, irq}, 32'h0);
  endtask : t_cal_ack

  // Edges of the window, then one result below and one above it
  task automatic t_cal_edges();
    set_meas(32'd1000, 32'd1000, 32'd1000);
    wr(ADDR_TGT_I, 32'd1000);
    wr(ADDR_TGT_V, 32'd1000);
    wr(ADDR_TGT_P, 32'd1000);
    wr(ADDR_GAIN_I, 32'd25000);
    wr(ADDR_GAIN_V, 32'd65535);
    wr(ADDR_GAIN_P, 32'd40000);
    run_cal(32'h2);
    wr(ADDR_IRQ_EN, 32'h1);
    wr(ADDR_IRQ_CLR, 32'h3);
    wr(ADDR_GAIN_I, 32'd24999);
    run_cal(32'h4);
    rd(ADDR_IRQ_STAT, 32'h2);
    check({31'h0, irq}, 32'h0); // Masked event
    wr(ADDR_GAIN_I, 32'd25000);
    wr(ADDR_TGT_V, 32'd1001);
    run_cal(32'h4);
    rd(ADDR_GAIN_I, 32'd25000);
    rd(ADDR_GAIN_V, 32'd65535);
    rd(ADDR_GAIN_P, 32'd40000);
  endtask : t_cal_edges

  // Trim added to the current sample without carry out; voltage passes untouched
  task automatic t_dc();
    wr(ADDR_CTRL, 32'h2);
    wr(ADDR_DC_TRIM, 32'h00fffff0);
    adc_i <= 24'h000005;
    adc_v <= 24'h123456;
    repeat (3) @(posedge clock);
    check({31'h0, hpf_bypass}, 32'h1);
    check({8'h0, adc_i_trim}, 32'h00fffff5);
    check({8'h0, adc_v_out}, 32'h00123456);
    wr(ADDR_CTRL, 32'h0);
    repeat (2) @(posedge clock);
    check({31'h0, hpf_bypass}, 32'h0);
  endtask : t_dc

  // Reset, then the scenarios in turn
  initial
  begin
    rst_n = 1'b0;
    adc_i = 24'h0;
    adc_v = 24'h0;
    meas_i = 32'h0;
    meas_v = 32'h0;
    meas_p = 32'h0;
    rms_raw_i = 32'h0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_range();
    t_phase();
    t_offsets();
    t_cal_ack();
    t_cal_edges();
    t_dc();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
